//--- common/asc_pkg.sv
/*
 * asc_pkg: constants, state codes and carrier types for the converter
 * sequence controller. Assumes a 32-bit APB master and 12-bit conversion data.
 */
package asc_pkg;
	// ------------------------------------------------------------
	// register indices (byte address is four times the index)
	// ------------------------------------------------------------
	localparam logic [7:0] IDX_TRIG_SELECT   = 8'h01;
	localparam logic [7:0] IDX_TRIG_IRQ_CTRL = 8'h02;
	localparam logic [7:0] IDX_SEQ_CONFIG    = 8'h03;
	localparam logic [7:0] IDX_SEQ_START     = 8'h05;
	localparam logic [7:0] IDX_STATUS0       = 8'h06;
	localparam logic [7:0] IDX_CMP_ENABLE    = 8'h07;
	localparam logic [7:0] IDX_CONV_FLAGS    = 8'h08;
	localparam logic [7:0] IDX_RESULT_BASE   = 8'h10;

	// ------------------------------------------------------------
	// field positions
	// ------------------------------------------------------------
	localparam int unsigned POS_TRIG_LEVEL  = 4;
	localparam int unsigned POS_TRIG_POL    = 3;
	localparam int unsigned POS_EXT_TRIG_EN = 2;
	localparam int unsigned POS_SEQ_IRQ_EN  = 1;
	localparam int unsigned POS_CMP_IRQ_EN  = 0;
	localparam int unsigned POS_JUSTIFY     = 7;
	localparam int unsigned POS_SEQ_LEN_LO  = 3;
	localparam int unsigned POS_FIFO        = 2;
	localparam int unsigned POS_FRZ_LO      = 0;
	localparam int unsigned POS_SEQ_DONE    = 7;
	localparam int unsigned JUSTIFY_SHIFT   = 4;

	// ------------------------------------------------------------
	// reset values
	// ------------------------------------------------------------
	localparam logic [4:0]  RST_TRIG_IRQ_CTRL = 5'h00;
	localparam logic [4:0]  RST_TRIG_SELECT   = 5'h00;
	localparam logic [7:0]  RST_SEQ_CONFIG    = 8'h20;
	localparam logic [15:0] RST_CMP_ENABLE    = 16'h0000;

	localparam logic [4:0]  TRIG_SRC_DEDICATED = 5'h10;
	localparam logic [1:0]  FRZ_FINISH         = 2'h2;
	localparam logic [1:0]  FRZ_IMMEDIATE      = 2'h3;

	typedef enum logic [2:0] {
		ST_IDLE = 3'b001,
		ST_WAIT = 3'b010,
		ST_CONV = 3'b100
	} asc_state_e;

	typedef struct packed {
		logic        psel;
		logic        penable;
		logic        pwrite;
		logic [11:0] paddr;
		logic [31:0] pwdata;
	} asc_apb_req_s;

	typedef struct packed {
		logic [31:0] prdata;
		logic        pready;
		logic        pslverr;
	} asc_apb_rsp_s;

	typedef struct packed {
		asc_state_e        st;
		logic [4:0]        trigIrqCtrl;
		logic [4:0]        trigSelect;
		logic [7:0]        seqConfig;
		logic [15:0]       cmpEnable;
		logic [15:0]       convFlags;
		logic              seqDone;
		logic [3:0]        resultCounter;
		logic [3:0]        convIndex;
		logic [19:0]       sync1;
		logic [19:0]       sync2;
		logic [19:0]       sync3;
		logic              trigStable;
		logic [15:0][15:0] results;
		logic [31:0]       prdata;
		logic              pslverr;
	} asc_state_s;
endpackage : asc_pkg

//--- core/asc_top.sv
/*
 * asc_top: sequence control of a 16-result converter with an APB slave.
 * Assumes an external converter that takes convReq and answers with a
 * one-cycle convDone pulse and 12-bit convData on core_clk.
 */
// Local design decision: register access over APB.
`timescale 1ns/100ps
`default_nettype none

// Operation
// - trigger enable set: selected analog channel or dedicated input starts sequences
// - analog channel as trigger source gets its digital input buffer enabled
// - external trigger ignored while converting in stop mode
// - sequence-done interrupt requested when flag set and enable is one
// - compare interrupt when enabled and a compare-enabled complete flag sets
// - level/polarity decode: falling, rising, low level, high level
// - any write to sequence configuration aborts the running sequence
// - results unsigned; left justified when bit is 0, right when 1
// - four length bits set conversions per sequence
// - length field is binary 1 to 15, zero meaning 16
// - reset length field selects four conversions
// - non-FIFO: Nth conversion goes into Nth result register
// - FIFO: counter runs across sequences and wraps to zero
// - result counter readable in status register
// - abort or start-register write clears result counter even in FIFO
// - result write sets that register's conversion-complete flag
// - FIFO mode disables compare interrupt and per-conversion compare enables
// - two-bit freeze field selects breakpoint response
// - freeze: 00 continue, 01 reserved, 10 finish then halt, 11 halt now
module asc_top (
	input  wire logic                  core_clk,
	input  wire logic                  arst_n,
	input  wire asc_pkg::asc_apb_req_s apbReq,
	output var  asc_pkg::asc_apb_rsp_s apbRsp,
	input  wire logic [15:0]           anaDigIn,
	input  wire logic [3:0]            dedicatedTriggerInputs,
	output logic      [15:0]           anaBufEnable,
	input  wire logic                  stopConverting,
	input  wire logic                  freezeMode,
	output logic                       convReq,
	input  wire logic                  convDone,
	input  wire logic [11:0]           convData,
	output logic                       seqDoneIrq,
	output logic                       compareIrq
);

	// ------------------------------------------------------------
	// decode helpers
	// ------------------------------------------------------------
	function automatic logic [4:0] seq_len(input logic [3:0] f);
		seq_len = (f == 4'h0) ? 5'h10 : {1'b0, f};
	endfunction : seq_len

	function automatic logic [11:0] reg_addr(input logic [7:0] idx);
		reg_addr = {2'b00, idx, 2'b00};
	endfunction : reg_addr

	asc_pkg::asc_state_s q;
	asc_pkg::asc_state_s d;

	logic        extEn;
	logic        trigLevel;
	logic        trigPol;
	logic        fifoMode;
	logic [1:0]  frzSel;
	logic [3:0]  lenField;
	logic        trigRaw;
	logic        trigFire;
	logic        setup;
	logic        wrAccess;
	logic        haltNow;
	logic        holdNext;
	logic        lastConv;
	logic [15:0] justified;
	logic [15:0] cmpEff;
	logic [31:0] rdMux;
	logic        rdHit;

	assign extEn     = q.trigIrqCtrl[asc_pkg::POS_EXT_TRIG_EN];
	assign trigLevel = q.trigIrqCtrl[asc_pkg::POS_TRIG_LEVEL];
	assign trigPol   = q.trigIrqCtrl[asc_pkg::POS_TRIG_POL];
	assign fifoMode  = q.seqConfig[asc_pkg::POS_FIFO];
	assign frzSel    = q.seqConfig[asc_pkg::POS_FRZ_LO +: 2];
	assign lenField  = q.seqConfig[asc_pkg::POS_SEQ_LEN_LO +: 4];

	// ------------------------------------------------------------
	// trigger selection and sensitivity
	// ------------------------------------------------------------
	// q.trigStable only follows once the second and third stage agree
	assign trigRaw = q.trigStable;

	always_comb
	begin
		anaBufEnable = 16'h0000;
		if (extEn && !q.trigSelect[4])
			anaBufEnable[q.trigSelect[3:0]] = 1'b1;
	end

	always_comb
	begin
		logic [19:0] agreeNew;
		logic        sel;
		agreeNew = q.sync3;
		sel      = q.trigSelect[4] ? q.sync3[16 + q.trigSelect[1:0]]
		                           : q.sync3[q.trigSelect[3:0]];
		sel      = sel & agreeNew[0] | sel;
		case ({trigLevel, trigPol})
			2'b00:   trigFire = q.trigStable & ~sel;
			2'b01:   trigFire = ~q.trigStable & sel;
			2'b10:   trigFire = ~sel;
			2'b11:   trigFire = sel;
			default: trigFire = 1'b0;
		endcase
		trigFire = trigFire & extEn & ~stopConverting;
	end

	// ------------------------------------------------------------
	// bus decode
	// ------------------------------------------------------------
	assign setup    = apbReq.psel & ~apbReq.penable;
	assign wrAccess = apbReq.psel & apbReq.penable & apbReq.pwrite;

	always_comb
	begin
		rdMux = 32'h0000_0000;
		rdHit = 1'b1;
		if (apbReq.paddr[11:6] == reg_addr(asc_pkg::IDX_RESULT_BASE) >> 6)
			rdMux = {16'h0000, q.results[apbReq.paddr[5:2]]};
		else if (apbReq.paddr == reg_addr(asc_pkg::IDX_TRIG_SELECT))
			rdMux = {27'h0, q.trigSelect};
		else if (apbReq.paddr == reg_addr(asc_pkg::IDX_TRIG_IRQ_CTRL))
			rdMux = {27'h0, q.trigIrqCtrl};
		else if (apbReq.paddr == reg_addr(asc_pkg::IDX_SEQ_CONFIG))
			rdMux = {24'h0, q.seqConfig};
		else if (apbReq.paddr == reg_addr(asc_pkg::IDX_SEQ_START))
			rdMux = 32'h0000_0000;
		else if (apbReq.paddr == reg_addr(asc_pkg::IDX_STATUS0))
			rdMux = {24'h0, q.seqDone, 3'h0, q.resultCounter};
		else if (apbReq.paddr == reg_addr(asc_pkg::IDX_CMP_ENABLE))
			rdMux = {16'h0, q.cmpEnable};
		else if (apbReq.paddr == reg_addr(asc_pkg::IDX_CONV_FLAGS))
			rdMux = {16'h0, q.convFlags};
		else
			rdHit = 1'b0;
	end

	// ------------------------------------------------------------
	// sequencer
	// ------------------------------------------------------------
	// immediate freeze drops the request; the converter must treat that as abort
	assign haltNow  = freezeMode && (frzSel == asc_pkg::FRZ_IMMEDIATE);
	assign holdNext = freezeMode && frzSel[1];
	assign lastConv = ({1'b0, q.convIndex} + 5'h01) == seq_len(lenField);
	assign justified = q.seqConfig[asc_pkg::POS_JUSTIFY]
	                 ? {4'h0, convData}
	                 : {convData, 4'h0};
	assign cmpEff = fifoMode ? 16'h0000 : q.cmpEnable;

	always_comb
	begin
		logic [15:0] setFlags;
		logic        setDone;
		d        = q;
		setFlags = 16'h0000;
		setDone  = 1'b0;
		d.sync1  = {dedicatedTriggerInputs, anaDigIn};
		d.sync2  = q.sync1;
		d.sync3  = q.sync2;
		d.sync1[0] = d.sync1[0];
		if (q.sync2 == q.sync3)
			d.trigStable = q.trigSelect[4] ? q.sync3[16 + q.trigSelect[1:0]]
			                               : q.sync3[q.trigSelect[3:0]];

		case (q.st)
			asc_pkg::ST_IDLE:
			begin
				if (trigFire)
				begin
					d.st        = asc_pkg::ST_WAIT;
					d.convIndex = 4'h0;
					if (!fifoMode)
						d.resultCounter = 4'h0;
				end
			end
			asc_pkg::ST_WAIT:
			begin
				if (!holdNext)
					d.st = asc_pkg::ST_CONV;
			end
			asc_pkg::ST_CONV:
			begin
				if (convDone && !haltNow)
				begin
					d.results[q.resultCounter] = justified;
					setFlags[q.resultCounter]  = 1'b1;
					d.resultCounter = q.resultCounter + 4'h1;
					d.convIndex     = q.convIndex + 4'h1;
					if (lastConv)
					begin
						setDone = 1'b1;
						d.st    = asc_pkg::ST_IDLE;
					end
					else
						d.st = asc_pkg::ST_WAIT;
				end
			end
			default:
				d.st = asc_pkg::ST_IDLE;
		endcase

		if (wrAccess)
		begin
			if (apbReq.paddr == reg_addr(asc_pkg::IDX_TRIG_SELECT))
				d.trigSelect = apbReq.pwdata[4:0];
			if (apbReq.paddr == reg_addr(asc_pkg::IDX_TRIG_IRQ_CTRL))
				d.trigIrqCtrl = apbReq.pwdata[4:0];
			if (apbReq.paddr == reg_addr(asc_pkg::IDX_CMP_ENABLE))
				d.cmpEnable = apbReq.pwdata[15:0];
			if (apbReq.paddr == reg_addr(asc_pkg::IDX_CONV_FLAGS))
				d.convFlags = q.convFlags & ~apbReq.pwdata[15:0];
			if (apbReq.paddr == reg_addr(asc_pkg::IDX_STATUS0)
			    && apbReq.pwdata[asc_pkg::POS_SEQ_DONE])
				d.seqDone = 1'b0;
			if (apbReq.paddr == reg_addr(asc_pkg::IDX_SEQ_CONFIG))
			begin
				d.seqConfig     = apbReq.pwdata[7:0];
				d.st            = asc_pkg::ST_IDLE;
				d.resultCounter = 4'h0;
				d.convIndex     = 4'h0;
				setFlags        = 16'h0000;
				setDone         = 1'b0;
			end
			if (apbReq.paddr == reg_addr(asc_pkg::IDX_SEQ_START))
			begin
				d.st            = asc_pkg::ST_WAIT;
				d.resultCounter = 4'h0;
				d.convIndex     = 4'h0;
				setFlags        = 16'h0000;
				setDone         = 1'b0;
			end
		end
		// hardware set wins over a same-cycle software clear
		d.convFlags = d.convFlags | setFlags;
		d.seqDone   = d.seqDone | setDone;

		if (setup)
		begin
			d.prdata  = rdMux;
			d.pslverr = ~rdHit;
		end
	end

	always_ff @(posedge core_clk or negedge arst_n)
	begin
		if (!arst_n)
		begin
			q             <= '0;
			q.st          <= asc_pkg::ST_IDLE;
			q.trigIrqCtrl <= asc_pkg::RST_TRIG_IRQ_CTRL;
			q.trigSelect  <= asc_pkg::RST_TRIG_SELECT;
			q.seqConfig   <= asc_pkg::RST_SEQ_CONFIG;
			q.cmpEnable   <= asc_pkg::RST_CMP_ENABLE;
		end
		else
			q <= d;
	end

	// ------------------------------------------------------------
	// outputs
	// ------------------------------------------------------------
	assign convReq    = (q.st == asc_pkg::ST_CONV) && !haltNow;
	assign seqDoneIrq = q.seqDone & q.trigIrqCtrl[asc_pkg::POS_SEQ_IRQ_EN];
	assign compareIrq = q.trigIrqCtrl[asc_pkg::POS_CMP_IRQ_EN] & ~fifoMode
	                  & |(q.convFlags & cmpEff);

	always_comb
	begin
		apbRsp.prdata  = q.prdata;
		apbRsp.pready  = apbReq.psel & apbReq.penable;
		apbRsp.pslverr = apbReq.psel & apbReq.penable & q.pslverr;
	end

	// ------------------------------------------------------------
	// checks
	// ------------------------------------------------------------
	default clocking cb @(posedge core_clk); endclocking
	default disable iff (!arst_n);

	a_cfg_write_abort: assert property (wrAccess
		&& apbReq.paddr == reg_addr(asc_pkg::IDX_SEQ_CONFIG)
		|=> q.st == asc_pkg::ST_IDLE && q.resultCounter == 4'h0)
		else $error("config write did not abort");
	a_start_clears_cnt: assert property (wrAccess
		&& apbReq.paddr == reg_addr(asc_pkg::IDX_SEQ_START)
		|=> q.resultCounter == 4'h0 && q.st == asc_pkg::ST_WAIT)
		else $error("start write did not clear counter");
	a_done_sets_flag: assert property (q.st == asc_pkg::ST_CONV && convDone && !haltNow
		&& !wrAccess |=> q.convFlags[$past(q.resultCounter)])
		else $error("complete flag not set");
	a_result_justify: assert property (q.st == asc_pkg::ST_CONV && convDone && !haltNow
		&& !wrAccess |=> q.results[$past(q.resultCounter)] == $past(justified))
		else $error("result not stored justified");
	a_counter_advance: assert property (q.st == asc_pkg::ST_CONV && convDone && !haltNow
		&& !wrAccess |=> q.resultCounter == $past(q.resultCounter) + 4'h1)
		else $error("result counter did not advance");
	a_seq_len_end: assert property (q.st == asc_pkg::ST_CONV && convDone && !haltNow
		&& !wrAccess && lastConv |=> q.seqDone && q.st == asc_pkg::ST_IDLE)
		else $error("sequence did not end at programmed length");
	a_no_trig_stop: assert property (stopConverting |-> !trigFire)
		else $error("trigger taken in stop mode");
	a_fifo_no_cmp: assert property (fifoMode |-> !compareIrq)
		else $error("compare interrupt in fifo mode");
	a_seq_irq: assert property (q.seqDone && q.trigIrqCtrl[asc_pkg::POS_SEQ_IRQ_EN]
		|-> seqDoneIrq)
		else $error("sequence interrupt missing");
	a_freeze_hold: assert property (freezeMode && frzSel == asc_pkg::FRZ_IMMEDIATE
		|-> !convReq)
		else $error("request during immediate freeze");

	// ------------------------------------------------------------
	// handshake, trigger path and counter placement
	// ------------------------------------------------------------
	// zero wait states: the master relies on pready in the first access cycle
	a_pready_access: assert property (apbReq.psel && apbReq.penable |-> apbRsp.pready)
		else $error("pready missing in access phase");
	a_buf_select: assert property (extEn && !q.trigSelect[4]
		|-> anaBufEnable == (16'h0001 << q.trigSelect[3:0]))
		else $error("selected channel buffer not enabled");
	a_buf_off: assert property (!extEn |-> anaBufEnable == 16'h0000)
		else $error("buffer enabled without external trigger");
	a_trig_disabled: assert property (!extEn |-> !trigFire)
		else $error("trigger taken while disabled");
	a_fifo_keep_cnt: assert property (q.st == asc_pkg::ST_IDLE && trigFire && fifoMode
		&& !wrAccess |=> q.resultCounter == $past(q.resultCounter))
		else $error("fifo counter cleared by trigger");
	a_plain_start: assert property (q.st == asc_pkg::ST_IDLE && trigFire && !fifoMode
		&& !wrAccess |=> q.resultCounter == 4'h0)
		else $error("plain sequence did not start at entry zero");
	a_finish_freeze: assert property (q.st == asc_pkg::ST_WAIT && holdNext
		&& !wrAccess |=> q.st == asc_pkg::ST_WAIT)
		else $error("new conversion started while frozen");
	a_seq_irq_off: assert property (!q.trigIrqCtrl[asc_pkg::POS_SEQ_IRQ_EN]
		|-> !seqDoneIrq)
		else $error("sequence interrupt while disabled");

	c_full_seq:   cover property (q.st == asc_pkg::ST_CONV && convDone && lastConv);
	c_frz_hold:   cover property (q.st == asc_pkg::ST_WAIT && holdNext);
	c_fifo_wrap:  cover property (fifoMode && q.resultCounter == 4'hF && convDone);
	c_trig_start: cover property (q.st == asc_pkg::ST_IDLE && trigFire);
	c_abort:      cover property (q.st == asc_pkg::ST_CONV && wrAccess
		&& apbReq.paddr == reg_addr(asc_pkg::IDX_SEQ_CONFIG));

endmodule : asc_top

`default_nettype wire

//--- bench/asc_conv_model.sv
/*
 * asc_conv_model: behavioural converter on the far side of the sequence
 * controller. Assumes convReq is a level held until convDone is seen.
 */
`timescale 1ns/100ps
`default_nettype none

module asc_conv_model (
	input  wire logic        core_clk,
	input  wire logic        arst_n,
	input  wire logic        convReq,
	input  wire logic        slow,
	output logic             convDone,
	output logic [11:0]      convData,
	output logic [7:0]       convCount
);
	logic [3:0] waitCnt;

	// data is only meaningful with convDone; otherwise it toggles so stale
	// values cannot pass for a fresh result
	always_ff @(posedge core_clk or negedge arst_n)
	begin
		if (!arst_n)
		begin
			waitCnt   <= 4'h0;
			convDone  <= 1'b0;
			convData  <= 12'hFFF;
			convCount <= 8'h00;
		end
		else
		begin
			convDone <= 1'b0;
			convData <= ~convData;
			if (!convReq || convDone)
				waitCnt <= 4'h0;
			else if (waitCnt == (slow ? 4'h6 : 4'h2))
			begin
				convDone  <= 1'b1;
				convData  <= {4'hA, convCount};
				convCount <= convCount + 8'h01;
				waitCnt   <= 4'h0;
			end
			else
				waitCnt <= waitCnt + 4'h1;
		end
	end
endmodule : asc_conv_model

`default_nettype wire

//--- bench/tb.sv
/*
 * tb: self-checking bench of the sequence controller over APB.
 * Assumes asc_conv_model answers the conversion requests.
 */
`timescale 1ns/100ps
`default_nettype none

`define CHK(nm, ex, got) \
	begin num_checks++; if ((got) !== (ex)) begin failures++; \
	$display("FAIL %s expected %h seen %h", nm, ex, got); end end

module tb;
	logic                  core_clk = 1'b0;
	logic                  arst_n   = 1'b0;
	asc_pkg::asc_apb_req_s req      = '0;
	asc_pkg::asc_apb_rsp_s rsp;
	logic [15:0]           anaDigIn = 16'h0000;
	logic [3:0]            dedTrig  = 4'h0;
	logic [15:0]           anaBufEnable;
	logic                  stopConv = 1'b0;
	logic                  frz      = 1'b0;
	logic                  slow     = 1'b0;
	logic                  convReq, convDone, seqDoneIrq, compareIrq;
	logic [11:0]           convData;
	logic [7:0]            convCount, base;
	logic [31:0]           rdData;
	logic                  rdErr;
	int                    failures = 0, num_checks = 0, cycles = 0;

	always #5 core_clk = ~core_clk;

	asc_top u_asc_top (.core_clk(core_clk), .arst_n(arst_n), .apbReq(req), .apbRsp(rsp),
		.anaDigIn(anaDigIn), .dedicatedTriggerInputs(dedTrig), .anaBufEnable(anaBufEnable),
		.stopConverting(stopConv), .freezeMode(frz), .convReq(convReq), .convDone(convDone),
		.convData(convData), .seqDoneIrq(seqDoneIrq), .compareIrq(compareIrq));
	asc_conv_model u_asc_conv_model (.core_clk(core_clk), .arst_n(arst_n), .convReq(convReq),
		.slow(slow), .convDone(convDone), .convData(convData), .convCount(convCount));

	// ----------------------------------------
	// bus tasks
	// ----------------------------------------
	task automatic apb(input logic w, input logic [11:0] a, input logic [31:0] d);
		int n;
		n = 0;
		@(posedge core_clk);
		req.psel    <= 1'b1;
		req.pwrite  <= w;
		req.paddr   <= a;
		req.pwdata  <= d;
		@(posedge core_clk);
		req.penable <= 1'b1;
		do
		begin
			@(posedge core_clk);
			n++;
		end
		while (rsp.pready !== 1'b1 && n < 20);
		rdData = rsp.prdata;
		rdErr  = rsp.pslverr;
		req.psel    <= 1'b0;
		req.penable <= 1'b0;
	endtask : apb

	task automatic wr(input logic [11:0] a, input logic [31:0] d);
		apb(1'b1, a, d);
	endtask : wr

	task automatic rc(input logic [11:0] a, input logic [31:0] e, input string nm);
		apb(1'b0, a, 32'h0);
		`CHK(nm, e, rdData)
	endtask : rc

	// polls the done flag; a bounded poll count stands in for a hang
	task automatic waitDone;
		int k;
		k = 0;
		do
		begin
			apb(1'b0, 12'h018, 32'h0);
			k++;
		end
		while (rdData[7] !== 1'b1 && k < 100);
		`CHK("seq done", 1'b1, rdData[7])
	endtask : waitDone

	task automatic final_report;
		$display("checks %0d mismatches %0d", num_checks, failures);
		if (failures == 0 && num_checks > 0)
			$display("Regression OK");
		else
			$display("Regression broken");
		$finish;
	endtask : final_report

	always @(posedge core_clk)
	begin
		cycles++;
		if (cycles == 30000)
		begin
			failures++;
			final_report();
		end
	end

	// ----------------------------------------
	// scenarios
	// ----------------------------------------
	initial
	begin
		repeat (12) @(posedge core_clk);
		arst_n <= 1'b1;
		rc(12'h00C, 32'h20, "config reset");
		rc(12'h008, 32'h00, "ctrl reset");
		apb(1'b0, 12'h0FC, 32'h0);
		`CHK("unmapped err", 1'b1, rdErr)
		// right justified, three conversions, sequence interrupt
		wr(12'h008, 32'h02);
		wr(12'h00C, 32'h98);
		base = convCount;
		wr(12'h014, 32'h0);
		waitDone();
		`CHK("seq irq", 1'b1, seqDoneIrq)
		for (int i = 0; i < 3; i++)
			rc(12'h040 + 12'(4 * i), {20'h0, 4'hA, 8'(base + i)}, "right");
		rc(12'h020, 32'h0007, "flags");
		wr(12'h018, 32'h80);
		@(negedge core_clk);
		`CHK("seq irq clr", 1'b0, seqDoneIrq)
		// left justified, sixteen conversions, slow converter
		wr(12'h020, 32'hFFFF);
		wr(12'h00C, 32'h00);
		slow <= 1'b1;
		base = convCount;
		wr(12'h014, 32'h0);
		waitDone();
		wr(12'h018, 32'h80);
		rc(12'h07C, {16'h0, 4'hA, 8'(base + 15), 4'h0}, "left16");
		rc(12'h020, 32'hFFFF, "flags16");
		slow <= 1'b0;
		// fifo: counter continues over a triggered sequence
		wr(12'h004, 32'h10);
		wr(12'h008, 32'h0C);
		wr(12'h00C, 32'h14);
		base = convCount;
		wr(12'h014, 32'h0);
		waitDone();
		wr(12'h018, 32'h80);
		rc(12'h018, 32'h02, "fifo cnt");
		dedTrig[0] <= 1'b1;
		waitDone();
		wr(12'h018, 32'h80);
		rc(12'h018, 32'h04, "fifo cnt2");
		rc(12'h04C, {16'h0, 4'hA, 8'(base + 3), 4'h0}, "fifo res3");
		dedTrig[0] <= 1'b0;
		wr(12'h014, 32'h0);
		rc(12'h018, 32'h00, "start clr");
		waitDone();
		wr(12'h018, 32'h80);
		// abort a running sequence
		slow <= 1'b1;
		wr(12'h00C, 32'h00);
		wr(12'h014, 32'h0);
		repeat (20) @(posedge core_clk);
		wr(12'h00C, 32'h00);
		repeat (20) @(posedge core_clk);
		`CHK("abort req", 1'b0, convReq)
		rc(12'h018, 32'h00, "abort status");
		slow <= 1'b0;
		// every trigger sensitivity on dedicated input one
		wr(12'h004, 32'h11);
		wr(12'h00C, 32'h08);
		for (int m = 0; m < 4; m++)
		begin
			// the previous pass leaves the counter at one; a config write clears it
			wr(12'h00C, 32'h08);
			wr(12'h008, 32'(m << 3));
			dedTrig[1] <= m[0];
			repeat (10) @(posedge core_clk);
			rc(12'h018, 32'h00, "trig off");
			dedTrig[1] <= ~m[0];
			repeat (6) @(posedge core_clk);
			wr(12'h008, 32'h04 | 32'(m << 3));
			repeat (10) @(posedge core_clk);
			apb(1'b0, 12'h018, 32'h0);
			`CHK("trig idle", 1'b0, rdData[7])
			dedTrig[1] <= m[0];
			waitDone();
			wr(12'h008, 32'h00);
			repeat (10) @(posedge core_clk);
			wr(12'h018, 32'h80);
		end
		// analog channel as trigger, blocked in stop mode
		wr(12'h004, 32'h05);
		wr(12'h008, 32'h1C);
		@(negedge core_clk);
		`CHK("buffer en", 16'h0020, anaBufEnable)
		stopConv <= 1'b1;
		anaDigIn[5] <= 1'b1;
		repeat (12) @(posedge core_clk);
		`CHK("stop block", 1'b0, convReq)
		stopConv <= 1'b0;
		waitDone();
		anaDigIn <= 16'h0000;
		wr(12'h008, 32'h00);
		repeat (10) @(posedge core_clk);
		wr(12'h018, 32'h80);
		// compare interrupt, then suppressed in fifo mode
		wr(12'h020, 32'hFFFF);
		wr(12'h01C, 32'h0001);
		wr(12'h008, 32'h01);
		wr(12'h00C, 32'h08);
		wr(12'h014, 32'h0);
		waitDone();
		`CHK("cmp irq", 1'b1, compareIrq)
		wr(12'h018, 32'h80);
		wr(12'h020, 32'hFFFF);
		wr(12'h00C, 32'h0C);
		wr(12'h014, 32'h0);
		waitDone();
		`CHK("fifo cmp", 1'b0, compareIrq)
		// breakpoint responses
		for (int f = 0; f < 4; f++)
		begin
			wr(12'h018, 32'h80);
			wr(12'h00C, 32'h08 | 32'(f));
			frz <= 1'b1;
			wr(12'h014, 32'h0);
			repeat (12) @(posedge core_clk);
			apb(1'b0, 12'h018, 32'h0);
			`CHK("freeze", (f < 2), rdData[7])
			frz <= 1'b0;
			waitDone();
		end
		final_report();
	end
endmodule : tb

`default_nettype wire
